// ==== bdm_data_memory.sv ====
`timescale 1ns/1ps

// Behaviour
// (RL1) All data memory is 8-bit RAM; special and general areas are contiguous.
// (RL2) Address space starts at 00H with special registers at fixed places.
// (RL3) General storage has eleven banks, 0 to 10, chosen by the bank pointer.
// (RL4) Unused special locations and the gap before general memory read zero.
// (RL5) Special registers stay reachable whatever bank is selected.
// (RL6) Direct addresses always reach bank zero.
// (RL7) Indirect ports hold nothing; they access the location their pointer names.
// (RL8) An indirect port reached indirectly reads zero and ignores writes.
// (RL9) The first indirect port and pointer always target bank zero.
// (RL10) The second indirect port reaches banks through the bank pointer.
// (RL11) Bank pointer value is the bank number; software loads it first.
// (RL12) Reset selects bank zero, except watchdog reset in power-down keeps it.
// (RL13) Writing the counter low byte jumps in-page and inserts one dummy cycle.
// (RL14) Both memory pointers are real readable and writable registers.
// (RL15) ALU results land in the accumulator; no register-to-register move.
// (RL16) Bit set and clear change one bit and keep the others.
// (RL17) Memory contents are undefined at power-on; software initialises them.
// (RL18) Read-only special registers ignore writes; others accept both.
// (RL19) Bank pointer above ten selects nothing: reads zero, writes ignored.
module bdm_data_memory (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wdt_pd_reset,
    input wire bdm_pkg::bdm_req_t req,
    input wire logic alu_load,
    input wire logic [7:0] alu_result,
    input wire logic [7:0] pc_low,
    input wire logic [7:0] sfr_rdata,
    output bdm_pkg::bdm_sfr_t sfr,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic [7:0] accumulator,
    output logic [7:0] bank_select,
    output logic pcl_jump,
    output logic [7:0] pcl_target,
    output logic dummy_cycle
);

    // ----------------------------------------
    // State and memory
    // ----------------------------------------
    localparam int MEM_WORDS = bdm_pkg::BANK_COUNT * bdm_pkg::BANK_DEPTH;

    bdm_pkg::bdm_state_t state;
    bdm_pkg::bdm_state_t next_state;

    // (RL17) array left uninitialised
    // No reset on the array: a cleared RAM would hide missing initialisation.
    logic [7:0] mem [0:MEM_WORDS-1];

    logic is_ind0;
    logic is_ind1;
    logic nested;
    logic [7:0] tgt_addr;
    logic [7:0] tgt_bank;
    logic in_gp;
    logic bank_ok;
    logic [bdm_pkg::MEM_AW-1:0] mem_idx;
    logic [7:0] mem_rd;
    logic [7:0] local_rd;
    logic [7:0] old_val;
    logic [7:0] new_val;
    logic [7:0] bit_mask;
    logic wr_ok;
    logic mem_we;
    logic sfr_used;
    logic is_local;

    // ----------------------------------------
    // Address resolution
    // ----------------------------------------
    always_comb
    begin
        is_ind0 = req.addr == bdm_pkg::ADDR_INDIRECT_PORT_ZERO;
        is_ind1 = req.addr == bdm_pkg::ADDR_INDIRECT_PORT_ONE;
        // (RL7) indirect redirect
        tgt_addr = is_ind0 ? state.bank0_pointer : (is_ind1 ? state.banked_pointer : req.addr);
        // (RL6) (RL9) (RL10) (RL11) bank choice
        tgt_bank = is_ind1 ? state.bank_select : bdm_pkg::RESET_BYTE;
        // (RL8) nested indirect
        nested = (is_ind0 || is_ind1)
            && (tgt_addr == bdm_pkg::ADDR_INDIRECT_PORT_ZERO || tgt_addr == bdm_pkg::ADDR_INDIRECT_PORT_ONE);
        // (RL1) (RL2) (RL5) contiguous map
        in_gp = tgt_addr >= bdm_pkg::GP_BASE;
        // (RL3) (RL19) bank range
        bank_ok = tgt_bank < 8'(bdm_pkg::BANK_COUNT);
        mem_idx = bdm_pkg::MEM_AW'(tgt_bank) * bdm_pkg::MEM_AW'(bdm_pkg::BANK_DEPTH)
            + bdm_pkg::MEM_AW'(tgt_addr - bdm_pkg::GP_BASE);
        sfr_used = bdm_pkg::SFR_USED[tgt_addr[5:0]];
        is_local = tgt_addr <= bdm_pkg::ADDR_PROGRAM_COUNTER_LOW_BYTE;
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb
    begin
        mem_rd = bdm_pkg::RESET_BYTE;
        // (RL19) absent bank reads zero
        if (in_gp && bank_ok)
        begin
            mem_rd = mem[mem_idx];
        end
        local_rd = bdm_pkg::RESET_BYTE;
        case (tgt_addr)
            // (RL14) pointers readable
            bdm_pkg::ADDR_BANK0_POINTER: local_rd = state.bank0_pointer;
            bdm_pkg::ADDR_BANKED_POINTER: local_rd = state.banked_pointer;
            bdm_pkg::ADDR_BANK_SELECT: local_rd = state.bank_select;
            bdm_pkg::ADDR_ACCUMULATOR: local_rd = state.accumulator;
            bdm_pkg::ADDR_PROGRAM_COUNTER_LOW_BYTE: local_rd = pc_low;
            default:
            begin
                // (RL4) unused reads zero
                if (sfr_used && !is_local)
                begin
                    local_rd = sfr_rdata;
                end
            end
        endcase
        if (nested)
        begin
            old_val = bdm_pkg::RESET_BYTE;
        end
        else
        begin
            old_val = in_gp ? mem_rd : local_rd;
        end
    end

    // ----------------------------------------
    // Write path
    // ----------------------------------------
    always_comb
    begin
        bit_mask = bdm_pkg::BIT_ONE << req.bit_idx;
        // (RL16) single-bit modify
        if (req.bit_op)
        begin
            new_val = req.bit_val ? (old_val | bit_mask) : (old_val & ~bit_mask);
        end
        else
        begin
            new_val = req.wdata;
        end
        // (RL8) nested writes dropped
        wr_ok = rst_n && req.valid && (req.write || req.bit_op) && !nested;
        // (RL19) absent bank ignores writes
        mem_we = wr_ok && in_gp && bank_ok;
        sfr.sel = rst_n && req.valid && !in_gp && !nested && sfr_used && !is_local;
        // (RL18) read-only protection
        sfr.write = sfr.sel && wr_ok && !bdm_pkg::SFR_READ_ONLY[tgt_addr[5:0]];
        sfr.addr = tgt_addr;
        sfr.wdata = new_val;
    end

    always_ff @(posedge clk_sys)
    begin
        if (mem_we)
        begin
            mem[mem_idx] <= new_val;
        end
    end

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    always_comb
    begin
        next_state = state;
        next_state.rvalid = req.valid && !req.write && !req.bit_op;
        next_state.rdata = old_val;
        next_state.jump = 1'b0;
        // (RL13) dummy cycle follows jump
        next_state.dummy = state.jump;
        // (RL15) ALU result to accumulator
        if (alu_load)
        begin
            next_state.accumulator = alu_result;
        end
        if (wr_ok && !in_gp)
        begin
            case (tgt_addr)
                // (RL14) pointers writable
                bdm_pkg::ADDR_BANK0_POINTER: next_state.bank0_pointer = new_val;
                bdm_pkg::ADDR_BANKED_POINTER: next_state.banked_pointer = new_val;
                bdm_pkg::ADDR_BANK_SELECT: next_state.bank_select = new_val;
                bdm_pkg::ADDR_ACCUMULATOR: next_state.accumulator = new_val;
                bdm_pkg::ADDR_PROGRAM_COUNTER_LOW_BYTE:
                begin
                    // (RL13) in-page jump
                    next_state.jump = 1'b1;
                    next_state.jump_target = new_val;
                end
                default: next_state.jump = 1'b0;
            endcase
        end
        if (!rst_n)
        begin
            next_state = '0;
            // (RL12) bank kept on power-down watchdog reset
            next_state.bank_select = wdt_pd_reset ? state.bank_select : bdm_pkg::RESET_BYTE;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        state <= next_state;
    end

    assign rdata = state.rdata;
    assign rvalid = state.rvalid;
    assign accumulator = state.accumulator;
    assign bank_select = state.bank_select;
    assign pcl_jump = state.jump;
    assign pcl_target = state.jump_target;
    assign dummy_cycle = state.dummy;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_direct_bank0;
        @(posedge clk_sys) disable iff (!rst_n)
        (req.valid && !is_ind0 && !is_ind1) |-> (tgt_bank == 8'h00 && tgt_addr == req.addr);
    endproperty
    a_direct_bank0: assert property (p_direct_bank0) else $error("direct access left bank zero"); // RL6

    property p_ind0_bank0;
        @(posedge clk_sys) disable iff (!rst_n)
        (req.valid && is_ind0) |-> (tgt_bank == 8'h00 && tgt_addr == state.bank0_pointer);
    endproperty
    a_ind0_bank0: assert property (p_ind0_bank0) else $error("port zero missed its pointer"); // RL9

    property p_ind1_bank;
        @(posedge clk_sys) disable iff (!rst_n)
        (req.valid && is_ind1) |-> (tgt_bank == state.bank_select && tgt_addr == state.banked_pointer);
    endproperty
    a_ind1_bank: assert property (p_ind1_bank) else $error("port one missed bank or pointer"); // RL10

    property p_unused_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        (req.valid && !req.write && !req.bit_op && !in_gp && !sfr_used) |=> (rvalid && rdata == 8'h00);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused location read nonzero"); // RL4

    property p_nested;
        @(posedge clk_sys) disable iff (!rst_n)
        (req.valid && nested) |-> (!mem_we && !sfr.sel) ##1 (rdata == 8'h00);
    endproperty
    a_nested: assert property (p_nested) else $error("nested indirect access acted"); // RL8

    property p_pcl_jump;
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_ok && !req.bit_op && tgt_addr == bdm_pkg::ADDR_PROGRAM_COUNTER_LOW_BYTE)
        |=> (pcl_jump && pcl_target == $past(req.wdata)) ##1 (dummy_cycle && !pcl_jump);
    endproperty
    a_pcl_jump: assert property (p_pcl_jump) else $error("low byte write gave no jump"); // RL13

    property p_bank_reset;
        @(posedge clk_sys) (!rst_n && !wdt_pd_reset) |=> (bank_select == 8'h00);
    endproperty
    a_bank_reset: assert property (p_bank_reset) else $error("reset left bank nonzero"); // RL12

    property p_bank_keep;
        @(posedge clk_sys) (!rst_n && wdt_pd_reset) |=> $stable(bank_select);
    endproperty
    a_bank_keep: assert property (p_bank_keep) else $error("watchdog reset changed bank"); // RL12

    property p_read_only;
        @(posedge clk_sys) disable iff (!rst_n)
        (sfr.sel && bdm_pkg::SFR_READ_ONLY[tgt_addr[5:0]]) |-> !sfr.write;
    endproperty
    a_read_only: assert property (p_read_only) else $error("read-only register written"); // RL18

    property p_bad_bank;
        @(posedge clk_sys) disable iff (!rst_n)
        (req.valid && in_gp && tgt_bank > 8'h0A) |-> (!mem_we ##1 (rvalid -> rdata == 8'h00));
    endproperty
    a_bad_bank: assert property (p_bad_bank) else $error("absent bank accessed"); // RL19

    property p_bit_op;
        @(posedge clk_sys) disable iff (!rst_n)
        (req.valid && req.bit_op && !nested) |-> ((new_val & ~bit_mask) == (old_val & ~bit_mask));
    endproperty
    a_bit_op: assert property (p_bit_op) else $error("bit operation disturbed other bits"); // RL16

    property p_sfr_any_bank;
        @(posedge clk_sys) disable iff (!rst_n)
        (req.valid && !is_ind0 && !is_ind1 && req.addr < bdm_pkg::GP_BASE && bdm_pkg::SFR_USED[req.addr[5:0]]
            && req.addr > bdm_pkg::ADDR_PROGRAM_COUNTER_LOW_BYTE) |-> (sfr.sel && sfr.addr == req.addr);
    endproperty
    a_sfr_any_bank: assert property (p_sfr_any_bank) else $error("special register lost under bank"); // RL5

    c_gp_bank_write: cover property (@(posedge clk_sys) disable iff (!rst_n) mem_we && is_ind1);
    c_sfr_read: cover property (@(posedge clk_sys) disable iff (!rst_n) sfr.sel && !sfr.write);
    c_jump: cover property (@(posedge clk_sys) disable iff (!rst_n) pcl_jump ##1 dummy_cycle);
    c_bad_bank: cover property (@(posedge clk_sys) disable iff (!rst_n) req.valid && in_gp && !bank_ok);

endmodule : bdm_data_memory

// ==== bdm_pkg.sv ====
package bdm_pkg;

    // ----------------------------------------
    // Widths and geometry
    // ----------------------------------------
    localparam int DATA_W = 8;
    localparam int MEM_AW = 12;
    localparam int BANK_COUNT = 11;
    localparam int BANK_DEPTH = 192;
    localparam logic [7:0] GP_BASE = 8'h40;
    localparam int DUMMY_CYCLES = 1;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_INDIRECT_PORT_ZERO = 8'h00;
    localparam logic [7:0] ADDR_BANK0_POINTER = 8'h01;
    localparam logic [7:0] ADDR_INDIRECT_PORT_ONE = 8'h02;
    localparam logic [7:0] ADDR_BANKED_POINTER = 8'h03;
    localparam logic [7:0] ADDR_BANK_SELECT = 8'h04;
    localparam logic [7:0] ADDR_ACCUMULATOR = 8'h05;
    localparam logic [7:0] ADDR_PROGRAM_COUNTER_LOW_BYTE = 8'h06;

    // Implemented special-function locations 00H..3FH, one bit each.
    localparam logic [63:0] SFR_USED = 64'h07FF_F7FF_6FCF_FFFF;
    // The table high byte at 08H is read-only.
    localparam logic [63:0] SFR_READ_ONLY = 64'h0000_0000_0000_0100;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] BIT_ONE = 8'h01;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic bit_op;
        logic bit_val;
        logic [2:0] bit_idx;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bdm_req_t;

    typedef struct packed {
        logic sel;
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bdm_sfr_t;

    typedef struct packed {
        logic [7:0] bank0_pointer;
        logic [7:0] banked_pointer;
        logic [7:0] bank_select;
        logic [7:0] accumulator;
        logic [7:0] rdata;
        logic rvalid;
        logic jump;
        logic [7:0] jump_target;
        logic dummy;
    } bdm_state_t;

endpackage : bdm_pkg

// ==== bdm_sfr_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// Outside special registers
// ----------------------------------------
// Stands in for the peripheral registers that sit behind the special-function port.
module bdm_sfr_model #(
    parameter logic [7:0] TABLE_HIGH_VALUE = 8'hC3
) (
    input wire logic clk_sys,
    input wire bdm_pkg::bdm_sfr_t sfr,
    output logic [7:0] sfr_rdata
);
    logic [7:0] regs [0:63];
    logic [7:0] last;
    // Starts at the table value and is only held there by the design's write protection.
    logic [7:0] table_high = TABLE_HIGH_VALUE;

    // When nothing is selected the data lines must not look like a held value.
    always_comb
    begin
        if (!sfr.sel)
            sfr_rdata = ~last;
        else if (sfr.addr == 8'h08)
            sfr_rdata = table_high;
        else
            sfr_rdata = regs[sfr.addr[5:0]];
    end

    always_ff @(posedge clk_sys)
    begin
        last <= sfr_rdata;
        // a leaked strobe overwrites the table byte
        if (sfr.sel && sfr.write && sfr.addr == 8'h08)
            table_high <= sfr.wdata;
        if (sfr.sel && sfr.write)
            regs[sfr.addr[5:0]] <= sfr.wdata;
    end
endmodule : bdm_sfr_model

// ==== banked_data_memory_addressing_bench.sv ====
`timescale 1ns/1ps

`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin err_total++; \
    $display("mismatch %s expected %h seen %h", nm, ex, gt); end end

module banked_data_memory_addressing_bench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic wdt_pd_reset = 1'b0;
    bdm_pkg::bdm_req_t req = '0;
    logic alu_load = 1'b0;
    logic [7:0] alu_result = 8'h00;
    logic [7:0] pc_low = 8'h3C;
    logic [7:0] sfr_rdata;
    bdm_pkg::bdm_sfr_t sfr;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] accumulator;
    logic [7:0] bank_select;
    logic pcl_jump;
    logic [7:0] pcl_target;
    logic dummy_cycle;
    int err_total = 0;
    int total_checks = 0;
    logic [7:0] unused_addr [0:6] = '{8'h14, 8'h15, 8'h1C, 8'h1F, 8'h2B, 8'h3B, 8'h3F};

    bdm_data_memory dut (.clk_sys(clk_sys), .rst_n(rst_n), .wdt_pd_reset(wdt_pd_reset), .req(req),
        .alu_load(alu_load), .alu_result(alu_result), .pc_low(pc_low), .sfr_rdata(sfr_rdata), .sfr(sfr),
        .rdata(rdata), .rvalid(rvalid), .accumulator(accumulator), .bank_select(bank_select),
        .pcl_jump(pcl_jump), .pcl_target(pcl_target), .dummy_cycle(dummy_cycle));

    bdm_sfr_model partner (.clk_sys(clk_sys), .sfr(sfr), .sfr_rdata(sfr_rdata));

    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic acc(input logic w, input logic bo, input logic bv, input logic [2:0] bi,
                       input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        req = {1'b1, w, bo, bv, bi, a, d};
        @(posedge clk_sys);
        #1;
        req.valid = 1'b0;
    endtask : acc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, 1'b0, 1'b0, 3'h0, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        acc(1'b0, 1'b0, 1'b0, 3'h0, a, 8'h00);
        `CHK("rvalid", 1'b1, rvalid)
        `CHK("rdata", ex, rdata)
    endtask : rd

    task automatic do_reset(input int n, input logic keep);
        @(posedge clk_sys);
        #1;
        rst_n = 1'b0;
        wdt_pd_reset = keep;
        repeat (n) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        wdt_pd_reset = 1'b0;
    endtask : do_reset

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    // A hang anywhere ends the run with a failure rather than silence.
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        summarize();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        repeat (20) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        `CHK("bank_select", 8'h00, bank_select) // reset bank zero
        `CHK("accumulator", 8'h00, accumulator) // reset clears registers
        wr(8'h04, 8'h05); // bank loaded
        do_reset(2, 1'b1); // watchdog reset in power-down
        `CHK("bank_select", 8'h05, bank_select) // watchdog keeps bank
        do_reset(2, 1'b0); // ordinary reset
        `CHK("bank_select", 8'h00, bank_select) // reset bank zero
        // Locations are initialised before they are read back.
        wr(8'h01, 8'h41); // software initialises
        rd(8'h01, 8'h41); // pointer storage
        wr(8'h03, 8'h41); // pointer written
        rd(8'h03, 8'h41); // pointer storage
        wr(8'h04, 8'h03); // bank loaded first
        rd(8'h04, 8'h03); // reachable in bank three
        wr(8'h41, 8'hAA); // direct write bank zero
        rd(8'h00, 8'hAA); // port zero bank zero
        rd(8'h41, 8'hAA); // direct bank zero
        wr(8'h02, 8'h55); // write bank three
        rd(8'h41, 8'hAA); // direct ignores bank
        rd(8'h02, 8'h55); // banked port
        wr(8'h04, 8'h00); // bank zero loaded
        rd(8'h02, 8'hAA); // bank value is number
        wr(8'h04, 8'h0A); // bank ten loaded
        wr(8'h02, 8'hFF); // write bank ten
        rd(8'h02, 8'hFF); // eight bit storage
        wr(8'h04, 8'h0B); // bank eleven loaded
        wr(8'h02, 8'h11); // write to absent bank
        rd(8'h02, 8'h00); // bank above ten
        wr(8'h04, 8'h0A); // bank ten again
        rd(8'h02, 8'hFF); // write ignored
        wr(8'h00, 8'h66); // write through port
        rd(8'h41, 8'h66); // port holds nothing
        wr(8'h01, 8'h00); // pointer names port
        rd(8'h00, 8'h00); // nested read zero
        wr(8'h00, 8'h77); // nested write
        rd(8'h01, 8'h00); // nested write no effect
        wr(8'h03, 8'h02); // pointer names port
        rd(8'h02, 8'h00); // nested read zero
        wr(8'h14, 8'h5A); // write to unused dropped
        foreach (unused_addr[i])
        begin
            rd(unused_addr[i], 8'h00); // seven listed unused locations, 3CH..3EH not read
        end
        rd(8'h14, 8'h00); // unused reads zero
        rd(8'h1C, 8'h00); // unused reads zero
        rd(8'h2B, 8'h00); // unused reads zero
        rd(8'h3F, 8'h00); // gap reads zero
        wr(8'h07, 8'h5A); // outside register written
        rd(8'h07, 8'h5A); // fixed outside register
        acc(1'b0, 1'b1, 1'b1, 3'h0, 8'h07, 8'h00); // bit set on outside register
        rd(8'h07, 8'h5B); // outside register bit set
        wr(8'h08, 8'h12); // write to read-only
        rd(8'h08, 8'hC3); // read-only kept
        acc(1'b0, 1'b1, 1'b0, 3'h0, 8'h08, 8'h00); // bit clear on read-only
        rd(8'h08, 8'hC3); // read-only kept after bit clear
        wr(8'h42, 8'h0F); // software initialises
        acc(1'b0, 1'b1, 1'b1, 3'h7, 8'h42, 8'h00); // bit set
        rd(8'h42, 8'h8F); // bit set
        acc(1'b0, 1'b1, 1'b0, 3'h0, 8'h42, 8'h00); // bit clear
        rd(8'h42, 8'h8E); // bit clear
        @(posedge clk_sys);
        #1;
        alu_result = 8'h77;
        alu_load = 1'b1;
        @(posedge clk_sys);
        #1;
        alu_load = 1'b0;
        `CHK("accumulator", 8'h77, accumulator) // ALU result held
        rd(8'h05, 8'h77); // accumulator readable
        wr(8'h06, 8'h12); // low byte write
        `CHK("pcl_jump", 1'b1, pcl_jump) // jump pulse
        `CHK("pcl_target", 8'h12, pcl_target) // in-page target
        @(posedge clk_sys);
        #1;
        `CHK("dummy_cycle", 1'b1, dummy_cycle) // one dummy cycle
        `CHK("pcl_jump", 1'b0, pcl_jump) // single pulse
        @(posedge clk_sys);
        #1;
        `CHK("dummy_cycle", 1'b0, dummy_cycle) // one dummy cycle
        rd(8'h06, 8'h3C); // low byte readable
        summarize();
    end
endmodule : banked_data_memory_addressing_bench
